// ===== rtl/sso_status_outputs.v
// servo status outputs: dynamic brake, zero flags, brake timing, terminals
//
// Behaviour
// - code 5 puts dynamic brake on terminal
// - severe alarm other than overload alone coasts motor at once
// - overload decelerates first, then coasts
// - dynamic brake latched until alarm reset
// - position mode: zero deviation within width
// - other modes hold zero deviation on
// - code 8 puts zero deviation on terminal
// - zero speed when speed within width
// - code 9 puts zero speed on terminal
// - brake timing follows servo-on input, held off by a severe alarm or latched dynamic brake
// - code 11 routes brake timing, else off
// - four codes select four output terminals
// - brake time 0.01 to 9.99 s steps
`timescale 1ns/1ps
`default_nettype none
`include "sso_defines.vh"

module sso_status_outputs (
  input  wire                      core_clk,
  input  wire                      rst,
  input  wire                      servo_on,
  input  wire                      alarm_reset,
  input  wire [`SSO_ALM_WIDTH-1:0] severe_alarm,
  input  wire                      decel_done,
  input  wire                      position_mode,
  input  wire [31:0]               position_deviation,
  input  wire [15:0]               zero_dev_width,
  input  wire [15:0]               motor_speed,
  input  wire [15:0]               zero_speed_width,
  input  wire [9:0]                brake_time,
  input  wire [7:0]                assign_code_1,
  input  wire [7:0]                assign_code_2,
  input  wire [7:0]                assign_code_3,
  input  wire [7:0]                assign_code_4,
  output wire [3:0]                sequence_output,
  output wire                      first_sequence_output,
  output reg                       dyn_brake,
  output reg                       zero_dev,
  output reg                       zero_speed,
  output reg                       brake_timing,
  output reg                       motor_drive,
  output reg                       max_decel,
  output reg                       brake_pending
);

  localparam [26:0] STEP_CYCLES = `SSO_STEP_CYCLES;

  // drive states; coast is where reset and every alarm path land
  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_HOLD  = 2'h1;
  localparam [1:0] ST_DECEL = 2'h2;
  localparam [1:0] ST_COAST = 2'h3;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [26:0] step_cnt;
  reg  [9:0]  steps_left;
  reg         servo_on_q;
  wire        any_severe;
  wire        overload_only;
  wire [31:0] dev_mag;
  wire [9:0]  brake_steps;
  wire [7:0]  codes [0:3];

  // magnitude of the signed position deviation
  function [31:0] abs32;
    input [31:0] v;
    begin
      abs32 = v[31] ? (~v + 32'h0000_0001) : v;
    end
  endfunction

  assign dev_mag = abs32(position_deviation);
  assign any_severe = |severe_alarm;
  assign overload_only = severe_alarm[`SSO_ALM_OVERLOAD] &&
                         ~|severe_alarm[`SSO_ALM_OVERLOAD-1:0];
  assign brake_steps = (brake_time > `SSO_BRAKE_MAX_STEPS) ? `SSO_BRAKE_MAX_STEPS
                                                           : brake_time;

  always @(posedge core_clk) begin
    if (rst) begin
      zero_dev   <= 1'b1;
      zero_speed <= 1'b1;
    end else begin
      zero_dev   <= ~position_mode || (dev_mag <= {16'h0000, zero_dev_width});
      zero_speed <= motor_speed <= zero_speed_width;
    end
  end

  // dynamic brake latched; a new alarm wins over reset
  always @(posedge core_clk) begin
    if (rst) begin
      dyn_brake <= 1'b0;
    end else if (any_severe) begin
      dyn_brake <= 1'b1;
    end else if (alarm_reset) begin
      dyn_brake <= 1'b0;
    end
  end

  // drive state machine
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (servo_on_q && !servo_on) begin
          next_state = (brake_steps == 10'h000) ? ST_COAST : ST_HOLD;
        end else if (!servo_on) begin
          next_state = ST_COAST;
        end
      end
      ST_HOLD: begin
        if (steps_left == 10'h000) begin
          next_state = ST_COAST;
        end
      end
      ST_DECEL: begin
        if (decel_done) begin
          next_state = ST_COAST;
        end
      end
      ST_COAST: begin
        if (servo_on && !dyn_brake) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_COAST;
    endcase
    // severe alarm coasts at once, overload alone decelerates first
    // the override follows the case so that it wins over each state's own transition, except in decel under overload alone
    if (any_severe) begin
      if (state == ST_COAST) begin
        // dyn_brake only rises next edge, so servo-on must not restart now
        next_state = ST_COAST;
      end else if (state == ST_DECEL) begin
        // a second alarm beside overload ends the deceleration
        if (!overload_only) begin
          next_state = ST_COAST;
        end
      end else begin
        next_state = overload_only ? ST_DECEL : ST_COAST;
      end
    end
  end

  // state, servo-on history and brake hold timer
  always @(posedge core_clk) begin
    if (rst) begin
      state      <= ST_COAST;
      servo_on_q <= 1'b0;
      step_cnt   <= 27'h000_0000;
      steps_left <= 10'h000;
    end else begin
      state      <= next_state;
      servo_on_q <= servo_on;
      if (state != ST_HOLD) begin
        step_cnt   <= 27'h000_0000;
        steps_left <= brake_steps;
      end else if (step_cnt == STEP_CYCLES - 27'h000_0001) begin
        step_cnt   <= 27'h000_0000;
        steps_left <= steps_left - 10'h001;
      end else begin
        step_cnt <= step_cnt + 27'h000_0001;
      end
    end
  end

  // drive outputs follow the next state so coasting is same-edge
  always @(posedge core_clk) begin
    if (rst) begin
      motor_drive   <= 1'b0;
      max_decel     <= 1'b0;
      brake_timing  <= 1'b0;
      brake_pending <= 1'b0;
    end else begin
      motor_drive   <= next_state != ST_COAST;
      max_decel     <= next_state == ST_DECEL;
      // release brake while servo-on and running
      brake_timing  <= next_state == ST_RUN && servo_on;
      brake_pending <= next_state == ST_HOLD;
    end
  end

  // flatten the code ports so the generate loop can index them
  assign codes[0] = assign_code_1;
  assign codes[1] = assign_code_2;
  assign codes[2] = assign_code_3;
  assign codes[3] = assign_code_4;

  genvar i;
  generate
    for (i = 0; i < `SSO_NUM_OUTPUTS; i = i + 1) begin : g_term
      sso_output_mux sso_output_mux_inst (
        .core_clk     (core_clk),
        .rst          (rst),
        .assign_code  (codes[i]),
        .dyn_brake    (dyn_brake),
        .zero_dev     (zero_dev),
        .zero_speed   (zero_speed),
        .brake_timing (brake_timing),
        .terminal     (sequence_output[i])
      );
    end
  endgenerate

  // the first terminal also has a pin of its own
  assign first_sequence_output = sequence_output[0];

endmodule
`default_nettype wire

// ===== rtl/sso_defines.vh
// constants for the servo status output block
`ifndef SSO_DEFINES_VH
`define SSO_DEFINES_VH

// output-terminal assignment codes
`define SSO_CODE_DYN_BRAKE  8'h05
`define SSO_CODE_ZERO_DEV   8'h08
`define SSO_CODE_ZERO_SPEED 8'h09
`define SSO_CODE_BRAKE_TIME 8'h0b
`define SSO_NUM_OUTPUTS     4

// brake operation time: units of 10 ms, legal 1..999, reset value 0
`define SSO_BRAKE_STEP_MS   10
`define SSO_BRAKE_MAX_STEPS 10'h3e7
`define SSO_BRAKE_RESET     10'h000
`define SSO_CLK_MHZ         100
// cycles in one 10 ms step at 100 MHz
`define SSO_STEP_CYCLES     27'h00f_4240

// severe alarm vector bit positions
`define SSO_ALM_OC1       0
`define SSO_ALM_OC2       1
`define SSO_ALM_OVERSPEED 2
`define SSO_ALM_OVERVOLT  3
`define SSO_ALM_ENC       4
`define SSO_ALM_CTRL_PWR  5
`define SSO_ALM_MEMORY    6
`define SSO_ALM_REGEN_OH  7
`define SSO_ALM_ENC_COMM  8
`define SSO_ALM_DUP_ASSGN 9
`define SSO_ALM_OVERLOAD  10
`define SSO_ALM_WIDTH     11

`endif

// ===== rtl/sso_output_mux.v
// one sequence output terminal: picks a function by assignment code
`timescale 1ns/1ps
`default_nettype none
`include "sso_defines.vh"

module sso_output_mux (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [7:0] assign_code,
  input  wire       dyn_brake,
  input  wire       zero_dev,
  input  wire       zero_speed,
  input  wire       brake_timing,
  output reg        terminal
);

  reg next_terminal;

  // route by code; unknown codes give a quiet low terminal
  always @* begin
    case (assign_code)
      `SSO_CODE_DYN_BRAKE:  next_terminal = dyn_brake;
      `SSO_CODE_ZERO_DEV:   next_terminal = zero_dev;
      `SSO_CODE_ZERO_SPEED: next_terminal = zero_speed;
      `SSO_CODE_BRAKE_TIME: next_terminal = brake_timing;
      default:              next_terminal = 1'b0;
    endcase
  end

  // registered so the terminal never glitches on a code change
  always @(posedge core_clk) begin
    if (rst) begin
      terminal <= 1'b0;
    end else begin
      terminal <= next_terminal;
    end
  end

endmodule
`default_nettype wire

// ===== tb/sso_status_monitor.sv
// assertion checker for the servo status outputs
`timescale 1ns/1ps
`default_nettype none
module sso_status_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        servo_on,
  input wire logic        alarm_reset,
  input wire logic [10:0] severe_alarm,
  input wire logic        decel_done,
  input wire logic        position_mode,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] zero_speed_width,
  input wire logic [7:0]  assign_code_1,
  input wire logic [7:0]  assign_code_4,
  input wire logic [3:0]  sequence_output,
  input wire logic        first_sequence_output,
  input wire logic        dyn_brake,
  input wire logic        zero_dev,
  input wire logic        zero_speed,
  input wire logic        brake_timing,
  input wire logic        motor_drive,
  input wire logic        max_decel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  alarm_coast_a: assert property (|severe_alarm[9:0] |=> !motor_drive)
    else $error("drive still applied after a severe alarm");
  dyn_set_a: assert property (|severe_alarm |=> dyn_brake)
    else $error("dynamic brake not raised by alarm");
  dyn_hold_a: assert property (dyn_brake && !alarm_reset |=> dyn_brake)
    else $error("dynamic brake dropped without reset");
  decel_first_a: assert property (severe_alarm == 11'h400 && motor_drive && !decel_done
    |=> max_decel && motor_drive)
    else $error("overload did not decelerate first");
  zero_speed_a: assert property (motor_speed <= zero_speed_width |=> zero_speed)
    else $error("zero speed flag low inside width");
  zero_dev_mode_a: assert property (!position_mode |=> zero_dev)
    else $error("zero deviation low outside position mode");
  term_dyn_a: assert property (assign_code_1 == 8'h05 && dyn_brake |=> first_sequence_output)
    else $error("terminal one misses dynamic brake");
  term_brake_a: assert property (assign_code_4 == 8'h0b
    |=> sequence_output[3] == $past(brake_timing))
    else $error("terminal four misses brake timing");
  servo_off_a: assert property (!servo_on |=> !brake_timing)
    else $error("brake released without servo on");
  cover property (max_decel ##1 !motor_drive);
  cover property (dyn_brake ##1 !dyn_brake);
  cover property ($rose(brake_timing));
endmodule
`default_nettype wire

// ===== tb/sso_host_model.sv
// host controller model: sets brake time and scans the terminals
`timescale 1ns/1ps
`default_nettype none
module sso_host_model #(
  parameter [9:0] BRAKE_STEPS = 10'h000
) (
  input  wire logic       core_clk,
  input  wire logic       slow_brake,
  input  wire logic [3:0] sequence_output,
  output var  logic [3:0] host_view,
  output var  logic [9:0] brake_time
);
  // brake time setting
  // zero skips the servo-off hold, so servo-off coasts at once
  // one step is a million cycles, so only entry into the hold is seen
  assign brake_time = slow_brake ? 10'h001 : BRAKE_STEPS;
  // scan only, restarts left to the scenarios
  always @(posedge core_clk) host_view <= sequence_output;
endmodule
`default_nettype wire

// ===== tb/sso_status_outputs_tb.sv
// self-checking bench for the servo status outputs
`timescale 1ns/1ps
`default_nettype none
module sso_status_outputs_tb;
  logic        core_clk, rst, servo_on, alarm_reset, decel_done, position_mode;
  logic [10:0] severe_alarm;
  logic [31:0] position_deviation;
  logic [15:0] zero_dev_width, motor_speed, zero_speed_width;
  logic [9:0]  brake_time;
  logic [7:0]  assign_code_1, assign_code_2, assign_code_3, assign_code_4;
  logic [3:0]  sequence_output, host_view;
  logic        first_sequence_output, dyn_brake, zero_dev, zero_speed, brake_timing;
  logic        motor_drive, max_decel, brake_pending, slow_brake;
  int          num_errors, n_compared;
  sso_status_outputs sso_status_outputs_inst (.core_clk, .rst, .servo_on, .alarm_reset,
    .severe_alarm, .decel_done, .position_mode, .position_deviation, .zero_dev_width,
    .motor_speed, .zero_speed_width, .brake_time, .assign_code_1, .assign_code_2,
    .assign_code_3, .assign_code_4, .sequence_output, .first_sequence_output, .dyn_brake,
    .zero_dev, .zero_speed, .brake_timing, .motor_drive, .max_decel, .brake_pending);
  sso_host_model sso_host_model_inst (.core_clk, .slow_brake, .sequence_output, .host_view,
    .brake_time);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [3:0] exp, input logic [3:0] act);
    n_compared++;
    if (act !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, act, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // deviation is a magnitude, so a negative value inside the width counts
  task automatic zero_flags;
    position_deviation = 32'hffff_fffb;
    step(1);
    chk(1'b1, zero_dev);
    position_deviation = 32'h0000_0006;
    step(1);
    chk(1'b0, zero_dev);
    position_mode = 0;
    step(1);
    chk(1'b1, zero_dev);
    motor_speed = 16'h000b;
    step(1);
    chk(1'b0, zero_speed);
    motor_speed = 16'h000a;
    step(1);
    chk(1'b1, zero_speed);
  endtask
  // terminal order is {brake timing, zero speed, zero deviation, dynamic brake}
  task automatic routing;
    motor_speed = 16'h000b;
    step(3);
    chk(4'h2, sequence_output);
    motor_speed = 16'h0000;
    step(3);
    chk(4'h6, sequence_output);
    chk(4'h6, host_view);
    assign_code_2 = 8'h00;
    step(2);
    chk(4'h4, sequence_output);
    assign_code_2 = 8'h08;
  endtask
  task automatic servo_cycle;
    servo_on = 1;
    step(3);
    chk(2'b11, {motor_drive, brake_timing});
    chk(4'he, sequence_output);
    servo_on = 0;
    step(3);
    chk(2'b00, {motor_drive, brake_timing});
  endtask
  task automatic alarms;
    for (int i = 0; i < 10; i++) begin
      servo_on = 1;
      step(3);
      severe_alarm = 11'h001 << i;
      step(1);
      chk(2'b10, {dyn_brake, motor_drive});
      alarm_reset = 1;
      step(2);
      chk(1'b1, first_sequence_output);
      severe_alarm = 11'h000;
      alarm_reset = 0;
      step(2);
      chk(1'b1, dyn_brake);
      alarm_reset = 1;
      step(1);
      chk(1'b0, dyn_brake);
      alarm_reset = 0;
    end
    servo_on = 0;
    step(2);
  endtask
  task automatic overload;
    servo_on = 1;
    step(3);
    severe_alarm = 11'h400;
    step(3);
    chk(2'b11, {max_decel, motor_drive});
    decel_done = 1;
    for (int t = 0; t < 10 && motor_drive !== 1'b0; t++) step(1);
    chk(1'b0, motor_drive);
    if (motor_drive !== 1'b0) wrap_up();
    severe_alarm = 11'h000;
    decel_done = 0;
    servo_on = 0;
    alarm_reset = 1;
    step(1);
    alarm_reset = 0;
  endtask
  // a nonzero brake time holds drive after servo-off; the hold is too
  // long to wait out, so a severe alarm ends it instead
  task automatic brake_hold;
    slow_brake = 1;
    servo_on = 1;
    step(3);
    servo_on = 0;
    step(2);
    chk(3'b101, {motor_drive, brake_timing, brake_pending});
    chk(4'h6, sequence_output);
    step(200);
    chk(3'b101, {motor_drive, brake_timing, brake_pending});
    severe_alarm = 11'h001;
    step(1);
    chk(3'b100, {dyn_brake, motor_drive, brake_pending});
    severe_alarm = 11'h000;
    alarm_reset = 1;
    step(1);
    alarm_reset = 0;
    slow_brake = 0;
  endtask
  initial begin
    rst = 1;
    servo_on = 0;
    alarm_reset = 0;
    decel_done = 0;
    position_mode = 1;
    severe_alarm = 11'h000;
    position_deviation = 32'h0000_0000;
    zero_dev_width = 16'h0005;
    motor_speed = 16'h0000;
    zero_speed_width = 16'h000a;
    assign_code_1 = 8'h05;
    assign_code_2 = 8'h08;
    assign_code_3 = 8'h09;
    assign_code_4 = 8'h0b;
    num_errors = 0;
    n_compared = 0;
    slow_brake = 0;
    step(4);
    rst = 0;
    zero_flags();
    routing();
    servo_cycle();
    alarms();
    overload();
    brake_hold();
    wrap_up();
  end
endmodule
bind sso_status_outputs sso_status_monitor sso_status_monitor_inst (.core_clk, .rst,
  .servo_on, .alarm_reset, .severe_alarm, .decel_done, .position_mode, .motor_speed,
  .zero_speed_width, .assign_code_1, .assign_code_4, .sequence_output,
  .first_sequence_output, .dyn_brake, .zero_dev, .zero_speed, .brake_timing,
  .motor_drive, .max_decel);
`default_nettype wire
